// [dv/brct_ref_model.sv]
/*
 * Far-side timing sources: reference oscillator and gated count clock.
 * Assumes a 1 ns time unit; both are unrelated in phase to mclk.
 */
`timescale 1ns/1ps
module brct_ref_model #(
    parameter real REF_HALF_NS = 135.635,
    parameter real CNT_HALF_NS = 101.3
)(
    input wire logic cnt_en,
    output logic ref_clk,
    output logic cnt_clk
);
    // ****************************************************************
    // Oscillator runs free; count clock stands low when not enabled
    // ****************************************************************
    initial
    begin
        ref_clk = 1'b0;
        forever #(REF_HALF_NS) ref_clk = ~ref_clk;
    end
    initial
    begin
        cnt_clk = 1'b0;
        forever #(CNT_HALF_NS) cnt_clk = cnt_en ? ~cnt_clk : 1'b0;
    end
endmodule // brct_ref_model

// [dv/tb_top.sv]
/*
 * Register-level bench of the generator, counter/timer and selectors.
 * Assumes the reference model supplies the oscillator and count pins.
 */
`timescale 1ns/1ps
module tb_top;
    import brct_pkg::*;
    // Ref tick and count tick periods in mclk cycles
    localparam real REF_T = 271.27 / 5.0;
    localparam real CNT_T = 202.6 / 5.0;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [DATA_W-1:0] reg_wdata = '0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [DATA_W-1:0] reg_rdata;
    logic ref_clk, cnt_clk, ct_out_level, ct_pin_out, ct_pin_oe, pin_w;
    logic cnt_en = 1'b0;
    logic [1:0] rx_char_seen = 2'h0;
    logic [NUM_SEL-1:0] clk16_out, bit_tick_out;
    logic [NUM_SEL-1:0][PHASE_W-1:0] bit_phase;
    int failures = 0;
    int check_count = 0;
    int cyc = 0;
    int n;
    always #2.5 mclk = ~mclk;
    // External pull-up holds the pin high when released
    assign pin_w = ct_pin_oe ? ct_pin_out : 1'b1;
    brct_ref_model ref_u (.cnt_en(cnt_en), .ref_clk(ref_clk),
        .cnt_clk(cnt_clk));
    brct_core dut_u (.mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .reference_clock_input(ref_clk),
        .input_pin_two(cnt_clk), .ext_timing_in({4{ref_clk}}),
        .rx_char_seen(rx_char_seen), .clk16_out(clk16_out),
        .bit_tick_out(bit_tick_out), .bit_phase_out(bit_phase),
        .ct_out_level(ct_out_level), .ct_pin_in(pin_w),
        .ct_pin_out(ct_pin_out), .ct_pin_oe(ct_pin_oe));
    // ****************************************************************
    // Compare, bus and wait tasks
    // ****************************************************************
    task automatic test_done();
        $display("Checks made %0d, mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic check_val(string nm, logic [7:0] e, logic [7:0] v);
        check_count++;
        if (v !== e)
        begin
            failures++;
            $display("Error %s expected %h seen %h", nm, e, v);
        end
    endtask
    task automatic check_rng(string nm, int lo, int hi, int v);
        check_count++;
        if (v < lo || v > hi)
        begin
            failures++;
            $display("Error %s expected %0d..%0d seen %0d", nm, lo, hi, v);
        end
    endtask
    task automatic wr(logic [3:0] a, logic [7:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(logic [3:0] a, logic [7:0] e, logic [7:0] m);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(negedge mclk);
        check_val("reg_rdata", e, reg_rdata & m);
    endtask
    function automatic logic evt(int i);
        if (i < 4)
            return clk16_out[i];
        if (i < 8)
            return bit_tick_out[i-4];
        return (i == 8) ? ct_out_level : ct_pin_oe;
    endfunction
    task automatic wait_evt(int i, int lim, output int k);
        k = 0;
        do
        begin
            @(negedge mclk);
            k++;
        end
        while (evt(i) !== 1'b1 && k < lim);
    endtask
    // Interval between two pulses, in ref ticks
    task automatic intv(int i, int ticks);
        int e;
        e = int'(ticks * REF_T);
        wait_evt(i, e + 60, n);
        wait_evt(i, e + 60, n);
        check_rng("pulse interval", e - 2, e + 2, n);
    endtask
    task automatic chr();
        @(posedge mclk);
        rx_char_seen <= 2'h2;
        @(posedge mclk);
        rx_char_seen <= 2'h0;
    endtask
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            failures++;
            test_done();
        end
    end
    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial
    begin
        repeat (4) @(posedge mclk);
        reset_n <= 1'b1;
        @(posedge mclk);
        rd(REG_AUX_MODE, 8'h00, 8'hff);
        rd(REG_CT_CTRL, 8'h00, 8'hff);
        rd(REG_DIV_HI, 8'h00, 8'hff);
        rd(4'hf, 8'h00, 8'hff);
        wr(REG_SEL_BASE + 4'h1, 8'h1a);
        intv(1, 6);
        wr(REG_AUX_MODE, 8'h01);
        wr(REG_SEL_BASE + 4'h1, 8'h1d);
        intv(1, 1);
        wr(REG_SEL_BASE + 4'h2, 8'h40);
        intv(2, 1);
        wr(REG_DIV_LO, 8'h02);
        rd(REG_DIV_LO, 8'h02, 8'hff);
        wr(REG_CT_CTRL, 8'h01);
        wr(REG_SEL_BASE, 8'h20);
        wr(REG_CT_CMD, 8'h01);
        intv(0, 4);
        intv(4, 64);
        check_val("bit_phase", 8'h00, {4'h0, bit_phase[0]});
        check_val("ct_pin_oe", 8'h01, {7'h0, ct_pin_oe});
        // Counter mode, pin in interrupt use
        wr(REG_CT_CTRL, 8'h08);
        wr(REG_CT_CMD, 8'h02);
        wr(REG_DIV_LO, 8'h03);
        wr(REG_CT_CMD, 8'h01);
        repeat (2) @(negedge mclk);
        wait_evt(8, 300, n);
        check_rng("delay", int'(2 * REF_T) - 2, int'(3 * REF_T) + 6, n);
        rd(REG_CT_CMD, 8'h05, 8'h0f);
        check_val("ct_pin_out", 8'h00, {7'h0, ct_pin_out});
        wr(REG_CT_CMD, 8'h02);
        rd(REG_CT_CMD, 8'h08, 8'h09);
        // Time-out mode, ready seen on the pin enable
        wr(REG_CT_CTRL, 8'h0a);
        wr(REG_DIV_LO, 8'h04);
        wr(REG_CT_CMD, 8'h01);
        repeat (5)
        begin
            chr();
            repeat (150) @(posedge mclk);
        end
        rd(REG_CT_CMD, 8'h00, 8'h01);
        chr();
        wait_evt(9, 400, n);
        check_rng("timeout", int'(3 * REF_T) - 2, int'(4 * REF_T) + 8, n);
        // Counter mode from the count clock pin
        wr(REG_CT_CTRL, 8'h04);
        wr(REG_CT_CMD, 8'h02);
        wr(REG_DIV_LO, 8'h02);
        cnt_en <= 1'b1;
        wr(REG_CT_CMD, 8'h01);
        repeat (2) @(negedge mclk);
        wait_evt(8, 300, n);
        check_rng("pin delay", int'(CNT_T) - 2, int'(2 * CNT_T) + 8, n);
        test_done();
    end
endmodule // tb_top

// [hdl/brct_bit_div.sv]
/*
 * Divide-by-16 of a 16x clock enable into bit ticks and bit phase.
 * Assumes tick16 is a one-cycle pulse on mclk.
 */
`timescale 1ns/1ps
module brct_bit_div
    import brct_pkg::*;
(
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic tick16,
    output logic bit_tick,
    output logic [PHASE_W-1:0] phase
);
    brct_div_t q;
    brct_div_t d;

    always_comb
    begin
        d = q;
        d.bit_tick = 1'b0;
        if (tick16)
        begin
            d.phase = PHASE_W'(q.phase + 4'h1); // RULE14
            d.bit_tick = (q.phase == PHASE_LAST); // RULE14
        end
    end

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            q <= DIV_RST;
        else
            q <= d;
    end

    assign bit_tick = q.bit_tick;
    assign phase = q.phase;

    chk_bit_wrap: assert property (@(posedge mclk) disable iff (!reset_n)
        tick16 && q.phase == PHASE_LAST |=> bit_tick && phase == 4'h0) // RULE14
        else $error("bit tick missing on phase wrap");
endmodule // brct_bit_div

// [hdl/brct_core.sv]
/*
 * Baud rate generator, 16-bit counter/timer and four clock selectors.
 * Assumes a host register port on mclk and asynchronous clock pins.
 */
// Added by the designer: the plain strobed port and the register offsets.
// Overview of operation
// [RULE1] Generator and counter/timer both time from the reference clock pin.
// [RULE2] Twenty-seven standard rates, 50 to 38.4K baud, chosen per direction.
// [RULE3] Auxiliary mode bit 0 adds rates up to 230.4K baud.
// [RULE4] System supplies a 3.6864 MHz reference for nominal rates.
// [RULE5] Every generator clock runs at sixteen times the bit rate.
// [RULE6] Four selectors pick generator, counter/timer or external input.
// [RULE7] Counter/timer is 16 bits, in counter, timer or time-out mode.
// [RULE8] Timer gives square wave, counter one delay, time-out measures gaps.
// [RULE9] Divisor is the high byte joined with the low byte.
// [RULE10] Start, stop, and read/write of both divisor bytes control it.
// [RULE11] Selected counter/timer output serves as a 16x clock.
// [RULE12] Timer output frequency is input clock over twice the divisor.
// [RULE13] Software never programs a divisor of 0 or 1.
// [RULE14] Each direction divides its 16x clock by 16, exposing phases.
// [RULE15] Counter/timer output goes to a pin and to every selector.
// [RULE16] Pin in interrupt use becomes open-drain, active low.
// [RULE17] Stop command clears a pending counter/timer ready flag.
// [RULE18] Input pin two may serve as external count clock.
// [RULE19] Timer reloads at terminal count, toggles output, runs on.
// [RULE20] Counter counts down once after start, flags ready at end.
// [RULE21] Time-out restarts on each character, flags if it expires.
`timescale 1ns/1ps
module brct_core
    import brct_pkg::*;
(
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DATA_W-1:0] reg_rdata,
    input wire logic reference_clock_input,
    input wire logic input_pin_two,
    input wire logic [NUM_SEL-1:0] ext_timing_in,
    input wire logic [1:0] rx_char_seen,
    output logic [NUM_SEL-1:0] clk16_out,
    output logic [NUM_SEL-1:0] bit_tick_out,
    output logic [NUM_SEL-1:0][PHASE_W-1:0] bit_phase_out,
    output logic ct_out_level,
    input wire logic ct_pin_in,
    output logic ct_pin_out,
    output logic ct_pin_oe
);
    brct_state_t q;
    brct_state_t d;
    logic [NUM_SYNC-1:0] sync_lvl;
    logic [NUM_SYNC-1:0] sync_rise;
    logic [NUM_SYNC-1:0] sync_pin;
    logic ref_tick;
    logic external_count_clock_rise;
    logic ct_tick;
    logic ct_end;
    logic ct_set_ready;
    logic cmd_wr;
    logic [CT_W-1:0] divisor;

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    assign sync_pin = {ext_timing_in, input_pin_two, reference_clock_input};

    genvar gi;
    generate
        for (gi = 0; gi < NUM_SYNC; gi++)
        begin : g_sync
            brct_sync u_sync (
                .mclk(mclk),
                .reset_n(reset_n),
                .pin_in(sync_pin[gi]),
                .level(sync_lvl[gi]),
                .rise(sync_rise[gi])
            );
        end
        for (gi = 0; gi < NUM_SEL; gi++)
        begin : g_div
            brct_bit_div u_div (
                .mclk(mclk),
                .reset_n(reset_n),
                .tick16(q.tick16[gi]),
                .bit_tick(bit_tick_out[gi]),
                .phase(bit_phase_out[gi])
            );
        end
    endgenerate

    assign ref_tick = sync_rise[0]; // RULE1
    assign external_count_clock_rise = sync_rise[1];
    assign divisor = {q.div_hi, q.div_lo}; // RULE9
    assign ct_tick = q.ct_src_ext ? external_count_clock_rise : ref_tick; // RULE18 RULE1
    // Divisors 0 and 1 both end at once; software must avoid them.
    assign ct_end = ct_tick && q.ct_run && q.ct_cnt <= CT_TERMINAL; // RULE13
    assign cmd_wr = reg_wr && reg_addr == REG_CT_CMD;

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb
    begin
        d = q;
        d.rd_data = '0;
        d.ct_16x = 1'b0;
        ct_set_ready = 1'b0;

        // Counter/timer countdown, one mode at a time
        if (q.ct_run && ct_tick)
        begin
            if (ct_end)
            begin
                case (q.ct_mode)
                    CT_COUNTER:
                    begin
                        d.ct_run = 1'b0; // RULE20 RULE8
                        d.ct_out = 1'b1;
                        ct_set_ready = 1'b1; // RULE20
                    end
                    CT_TIMEOUT:
                    begin
                        d.ct_run = 1'b0;
                        ct_set_ready = 1'b1; // RULE21 RULE8
                    end
                    default:
                    begin
                        d.ct_cnt = divisor; // RULE19
                        d.ct_out = ~q.ct_out; // RULE19 RULE12
                        d.ct_16x = ~q.ct_out; // RULE11
                        ct_set_ready = ~q.ct_out;
                    end
                endcase
            end
            else
            begin
                d.ct_cnt = CT_W'(q.ct_cnt - CT_TERMINAL); // RULE7
            end
        end

        // Each received character restarts an armed time-out
        if (q.ct_mode == CT_TIMEOUT && q.ct_armed && |rx_char_seen)
        begin
            d.ct_cnt = divisor; // RULE21
            d.ct_run = 1'b1; // RULE21
        end

        // Commands; stop in timer mode disarms and drops the ready flag but leaves it running
        if (cmd_wr && reg_wdata[CMD_START_BIT])
        begin
            d.ct_cnt = divisor; // RULE10 RULE9
            d.ct_run = 1'b1;
            d.ct_armed = 1'b1;
            d.ct_out = (q.ct_mode == CT_COUNTER) ? 1'b0 : q.ct_out;
            d.ct_16x = 1'b0;
        end
        else if (cmd_wr && reg_wdata[CMD_STOP_BIT])
        begin
            d.ct_armed = 1'b0; // RULE10
            if (q.ct_mode != CT_TIMER)
                d.ct_run = 1'b0;
        end
        // Set wins over a stop in the same cycle
        d.ct_ready = (q.ct_ready & ~(cmd_wr & reg_wdata[CMD_STOP_BIT]))
            | ct_set_ready; // RULE17

        // Register writes
        if (reg_wr)
        begin
            case (reg_addr)
                REG_AUX_MODE: d.aux_ext = reg_wdata[AUX_EXT_BIT]; // RULE3
                REG_CT_CTRL:
                begin
                    d.ct_mode = brct_mode_t'(
                        reg_wdata[CTRL_MODE_LSB +: 2]); // RULE7
                    d.ct_src_ext = reg_wdata[CTRL_SRC_BIT]; // RULE18
                    d.ct_pin_irq = reg_wdata[CTRL_PINIRQ_BIT];
                end
                REG_DIV_LO: d.div_lo = reg_wdata; // RULE10
                REG_DIV_HI: d.div_hi = reg_wdata; // RULE10
                REG_SEL_BASE, 4'h5, 4'h6, REG_SEL_LAST:
                begin
                    d.sel[2'(reg_addr - REG_SEL_BASE)] = brct_sel_t'(
                        reg_wdata[SEL_SRC_LSB + 1:SEL_RATE_LSB]); // RULE6
                end
                default:
                begin
                end
            endcase
        end

        // Register reads, data valid the cycle after the strobe
        if (reg_rd)
        begin
            case (reg_addr)
                REG_AUX_MODE: d.rd_data[AUX_EXT_BIT] = q.aux_ext;
                REG_CT_CTRL:
                begin
                    d.rd_data[CTRL_MODE_LSB +: 2] = q.ct_mode;
                    d.rd_data[CTRL_SRC_BIT] = q.ct_src_ext;
                    d.rd_data[CTRL_PINIRQ_BIT] = q.ct_pin_irq;
                end
                REG_DIV_LO: d.rd_data = q.div_lo; // RULE10
                REG_DIV_HI: d.rd_data = q.div_hi; // RULE10
                REG_SEL_BASE, 4'h5, 4'h6, REG_SEL_LAST:
                begin
                    d.rd_data[SEL_SRC_LSB + 1:SEL_RATE_LSB] =
                        q.sel[2'(reg_addr - REG_SEL_BASE)];
                end
                REG_CT_CMD:
                begin
                    d.rd_data[STAT_READY_BIT] = q.ct_ready;
                    d.rd_data[STAT_RUN_BIT] = q.ct_run;
                    d.rd_data[STAT_OUT_BIT] = q.ct_out;
                    d.rd_data[STAT_PIN_BIT] = ct_pin_in;
                end
                REG_CNT_LO: d.rd_data = q.ct_cnt[DATA_W-1:0];
                REG_CNT_HI: d.rd_data = q.ct_cnt[CT_W-1:DATA_W];
                default: d.rd_data = '0;
            endcase
        end

        // Per-direction generator divider and clock selector
        for (int i = 0; i < NUM_SEL; i++)
        begin
            d.tick16[i] = 1'b0;
            if (rate_div(q.sel[i].rate, q.aux_ext) == GEN_OFF)
            begin
                d.gen_cnt[i] = GEN_OFF;
            end
            else if (ref_tick)
            begin
                if (q.gen_cnt[i] >=
                    GEN_W'(rate_div(q.sel[i].rate, q.aux_ext) - GEN_ONE))
                begin
                    d.gen_cnt[i] = GEN_OFF;
                    d.tick16[i] = (q.sel[i].src == SRC_GEN); // RULE2 RULE5
                end
                else
                begin
                    d.gen_cnt[i] = GEN_W'(q.gen_cnt[i] + GEN_ONE);
                end
            end
            case (q.sel[i].src)
                SRC_CT: d.tick16[i] = q.ct_16x; // RULE11 RULE15 RULE6
                SRC_EXT: d.tick16[i] = sync_rise[2 + i]; // RULE6
                SRC_GEN:
                begin
                end
                default: d.tick16[i] = 1'b0;
            endcase
        end

        // Output pin: counter/timer output level, or open-drain active-low request
        if (q.ct_pin_irq)
        begin
            d.pin_o = 1'b0; // RULE16
            d.pin_oe = d.ct_ready; // RULE16
        end
        else
        begin
            d.pin_o = d.ct_out; // RULE15
            d.pin_oe = 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            q <= STATE_RST;
        else
            q <= d;
    end

    assign reg_rdata = q.rd_data;
    assign clk16_out = q.tick16;
    assign ct_out_level = q.ct_out;
    assign ct_pin_out = q.pin_o;
    assign ct_pin_oe = q.pin_oe;

    // ****************************************************************
    // Checks
    // ****************************************************************
    chk_stop_clears_ready: assert property (@(posedge mclk)
        disable iff (!reset_n)
        cmd_wr && reg_wdata[CMD_STOP_BIT] && !reg_wdata[CMD_START_BIT]
        && !ct_set_ready |=> !q.ct_ready) // RULE17
        else $error("stop did not clear ready");

    chk_start_loads_div: assert property (@(posedge mclk)
        disable iff (!reset_n)
        cmd_wr && reg_wdata[CMD_START_BIT]
        |=> q.ct_run && q.ct_cnt == $past(divisor)) // RULE9
        else $error("start did not load divisor");

    chk_timer_reload: assert property (@(posedge mclk)
        disable iff (!reset_n)
        ct_end && q.ct_mode == CT_TIMER && !cmd_wr && !reg_wr
        |=> q.ct_cnt == divisor && q.ct_out != $past(q.ct_out)
        && q.ct_run) // RULE19
        else $error("timer did not reload and toggle");

    chk_counter_once: assert property (@(posedge mclk)
        disable iff (!reset_n)
        ct_end && q.ct_mode == CT_COUNTER && !cmd_wr
        |=> q.ct_ready && !q.ct_run
        ##1 (!q.ct_run || $past(cmd_wr))) // RULE20
        else $error("counter did not stop with ready");

    chk_timeout_restart: assert property (@(posedge mclk)
        disable iff (!reset_n)
        q.ct_mode == CT_TIMEOUT && q.ct_armed && |rx_char_seen && !cmd_wr
        && !reg_wr |=> q.ct_run && q.ct_cnt == divisor) // RULE21
        else $error("time-out not restarted by character");

    chk_ct_16x_rise: assert property (@(posedge mclk)
        disable iff (!reset_n)
        q.ct_16x |-> q.ct_out && !$past(q.ct_out)) // RULE11
        else $error("16x pulse without output rise");

    chk_sel_ct_route: assert property (@(posedge mclk)
        disable iff (!reset_n)
        q.ct_16x && q.sel[0].src == SRC_CT && !reg_wr
        |=> clk16_out[0]) // RULE15
        else $error("counter/timer clock not routed");

    chk_ext_rate_gate: assert property (@(posedge mclk)
        disable iff (!reset_n)
        q.sel[1].src == SRC_GEN && q.sel[1].rate >= 5'h1b
        && !q.aux_ext && !reg_wr |=> !clk16_out[1]) // RULE3
        else $error("extended rate without auxiliary bit");

    chk_pin_open_drain: assert property (@(posedge mclk)
        disable iff (!reset_n)
        q.ct_pin_irq && !reg_wr |=> !ct_pin_out
        && ct_pin_oe == q.ct_ready) // RULE16
        else $error("pin not open-drain in interrupt use");

    chk_rdata_slot: assert property (@(posedge mclk)
        disable iff (!reset_n)
        !reg_rd |=> reg_rdata == '0)
        else $error("read data outside its slot");

    cov_timer_toggle: cover property (@(posedge mclk)
        disable iff (!reset_n) ct_end && q.ct_mode == CT_TIMER);
    cov_counter_done: cover property (@(posedge mclk)
        disable iff (!reset_n) ct_end && q.ct_mode == CT_COUNTER);
    cov_timeout_flag: cover property (@(posedge mclk)
        disable iff (!reset_n) ct_end && q.ct_mode == CT_TIMEOUT);
endmodule // brct_core

// [hdl/brct_pkg.sv]
/*
 * Shared constants, register map and state types of the baud rate and
 * counter/timer block. Assumes an 8-bit register port with 4-bit address.
 */
package brct_pkg;

    // ****************************************************************
    // Sizes
    // ****************************************************************
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam int CT_W = 16;
    localparam int GEN_W = 13;
    localparam int RATE_W = 5;
    localparam int NUM_SEL = 4;
    localparam int NUM_SYNC = 6;
    localparam int PHASE_W = 4;
    localparam logic [PHASE_W-1:0] PHASE_LAST = 4'hf;
    localparam logic [CT_W-1:0] CT_TERMINAL = 16'h0001;
    localparam logic [GEN_W-1:0] GEN_ONE = 13'h0001;
    localparam logic [GEN_W-1:0] GEN_OFF = 13'h0000;

    // ****************************************************************
    // Register offsets
    // ****************************************************************
    localparam logic [ADDR_W-1:0] REG_AUX_MODE = 4'h0;
    localparam logic [ADDR_W-1:0] REG_CT_CTRL = 4'h1;
    localparam logic [ADDR_W-1:0] REG_DIV_LO = 4'h2;
    localparam logic [ADDR_W-1:0] REG_DIV_HI = 4'h3;
    localparam logic [ADDR_W-1:0] REG_SEL_BASE = 4'h4;
    localparam logic [ADDR_W-1:0] REG_SEL_LAST = 4'h7;
    localparam logic [ADDR_W-1:0] REG_CT_CMD = 4'h8;
    localparam logic [ADDR_W-1:0] REG_CNT_LO = 4'h9;
    localparam logic [ADDR_W-1:0] REG_CNT_HI = 4'ha;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int AUX_EXT_BIT = 0;
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_SRC_BIT = 2;
    localparam int CTRL_PINIRQ_BIT = 3;
    localparam int CMD_START_BIT = 0;
    localparam int CMD_STOP_BIT = 1;
    localparam int STAT_READY_BIT = 0;
    localparam int STAT_RUN_BIT = 1;
    localparam int STAT_OUT_BIT = 2;
    localparam int STAT_PIN_BIT = 3;
    localparam int SEL_RATE_LSB = 0;
    localparam int SEL_SRC_LSB = 5;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [1:0] {CT_COUNTER, CT_TIMER, CT_TIMEOUT, CT_RSVD}
        brct_mode_t;
    typedef enum logic [1:0] {SRC_GEN, SRC_CT, SRC_EXT, SRC_NONE}
        brct_src_t;

    typedef struct packed {
        brct_src_t src;
        logic [RATE_W-1:0] rate;
    } brct_sel_t;

    typedef struct packed {
        logic aux_ext;
        brct_mode_t ct_mode;
        logic ct_src_ext;
        logic ct_pin_irq;
        logic [DATA_W-1:0] div_lo;
        logic [DATA_W-1:0] div_hi;
        brct_sel_t [NUM_SEL-1:0] sel;
        logic [CT_W-1:0] ct_cnt;
        logic ct_run;
        logic ct_armed;
        logic ct_out;
        logic ct_ready;
        logic ct_16x;
        logic [NUM_SEL-1:0][GEN_W-1:0] gen_cnt;
        logic [NUM_SEL-1:0] tick16;
        logic [DATA_W-1:0] rd_data;
        logic pin_o;
        logic pin_oe;
    } brct_state_t;

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic level;
        logic rise;
    } brct_sync_t;

    typedef struct packed {
        logic [PHASE_W-1:0] phase;
        logic bit_tick;
    } brct_div_t;

    localparam brct_state_t STATE_RST = '0;
    localparam brct_sync_t SYNC_RST = '0;
    localparam brct_div_t DIV_RST = '0;

    // ****************************************************************
    // Rate table: divisor of reference ticks per 16x pulse
    // ****************************************************************
    // Zero means no clock; extended codes need the auxiliary bit.
    function automatic logic [GEN_W-1:0] rate_div(
        input logic [RATE_W-1:0] code,
        input logic ext
    );
        logic [GEN_W-1:0] r;
        r = GEN_OFF;
        case (code)
            5'h00: r = 13'h1200;
            5'h01: r = 13'h0c00;
            5'h02: r = 13'h082e;
            5'h03: r = 13'h06b1;
            5'h04: r = 13'h0780;
            5'h05: r = 13'h0600;
            5'h06: r = 13'h0480;
            5'h07: r = 13'h03c0;
            5'h08: r = 13'h0300;
            5'h09: r = 13'h01e0;
            5'h0a: r = 13'h0180;
            5'h0b: r = 13'h0100;
            5'h0c: r = 13'h00db;
            5'h0d: r = 13'h00c0;
            5'h0e: r = 13'h0080;
            5'h0f: r = 13'h0073;
            5'h10: r = 13'h0060;
            5'h11: r = 13'h0050;
            5'h12: r = 13'h0040;
            5'h13: r = 13'h0030;
            5'h14: r = 13'h0028;
            5'h15: r = 13'h0020;
            5'h16: r = 13'h0018;
            5'h17: r = 13'h0010;
            5'h18: r = 13'h000c;
            5'h19: r = 13'h0008;
            5'h1a: r = 13'h0006;
            5'h1b: r = ext ? 13'h0004 : GEN_OFF; // RULE3
            5'h1c: r = ext ? 13'h0002 : GEN_OFF; // RULE3
            5'h1d: r = ext ? 13'h0001 : GEN_OFF; // RULE3
            default: r = GEN_OFF;
        endcase
        return r;
    endfunction

endpackage

// [hdl/brct_sync.sv]
/*
 * Three-stage input synchroniser with level and rising-edge pulse.
 * Assumes the input is asynchronous to mclk and much slower.
 */
`timescale 1ns/1ps
module brct_sync
    import brct_pkg::*;
(
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic pin_in,
    output logic level,
    output logic rise
);
    brct_sync_t q;
    brct_sync_t d;

    // ****************************************************************
    // Level accepted only when stages two and three agree
    // ****************************************************************
    always_comb
    begin
        d = q;
        d.s1 = pin_in;
        d.s2 = q.s1;
        d.s3 = q.s2;
        d.rise = 1'b0;
        if (q.s2 == q.s3)
        begin
            d.level = q.s3;
            d.rise = q.s3 & ~q.level;
        end
    end

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            q <= SYNC_RST;
        else
            q <= d;
    end

    assign level = q.level;
    assign rise = q.rise;
endmodule // brct_sync
